// file: rtl/iox_device.sv
// iox_device.sv: expander slave, register pairs, read path, interrupt
// assumes scl/sda are from another domain and pass a two-flop sampler
`timescale 1ns/1ps
`default_nettype none
`include "iox_consts.svh"
module iox_device #(
   parameter int WIDTH = 8
) (
   input wire logic sys_clk_in,
   input wire logic rst_b_in,
   iox_link_if.device link,
   input wire logic [2*WIDTH-1:0] port_pins_in,
   output logic [2*WIDTH-1:0] port_drive_out,
   output logic [2*WIDTH-1:0] port_oe_out,
   output logic int_b_out
);
   import iox_pkg::*;
   typedef enum logic [2:0] {IOX_IDLE, IOX_ADDR, IOX_CMD, IOX_WDAT, IOX_RDAT,
      IOX_RACK} iox_dev_state_t;
   iox_dev_state_t state;
   logic [2:0] scl_s, sda_s;
   logic scl_r, scl_f, st_cond, sp_cond;
   logic [7:0] sh;
   logic [3:0] bitn;
   logic ack_slot;
   logic [2:0] ptr;
   logic [7:0] ld_byte;
   logic [WIDTH-1:0] in_q [2];
   logic [WIDTH-1:0] out_q [2];
   logic [WIDTH-1:0] pol_q [2];
   logic [WIDTH-1:0] cfg_q [2];
   logic [WIDTH-1:0] int_ref [2];
   logic [2*WIDTH-1:0] pin_s1, pin_s2;
   logic [WIDTH-1:0] live [2];

   // register read mux for the current pointer
   function automatic logic [7:0] rd_mux(input logic [2:0] p,
      input logic [WIDTH-1:0] l0, input logic [WIDTH-1:0] l1);
      logic [7:0] v;
      v = 8'h00;
      case (p[2:1])
         2'd0: v = 8'(p[0] ? l1 : l0);
         2'd1: v = 8'(out_q[p[0]]);
         2'd2: v = 8'(pol_q[p[0]]);
         default: v = 8'(cfg_q[p[0]]);
      endcase
      return v;
   endfunction : rd_mux

   // two-flop samplers for link and pins
   always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         scl_s <= 3'h7;
         sda_s <= 3'h7;
         pin_s1 <= '0;
         pin_s2 <= '0;
      end else begin
         scl_s <= {scl_s[1:0], link.scl};
         sda_s <= {sda_s[1:0], link.sda};
         pin_s1 <= port_pins_in;
         pin_s2 <= pin_s1;
      end
   end
   assign scl_r = scl_s[1] & ~scl_s[2];
   assign scl_f = ~scl_s[1] & scl_s[2];
   assign st_cond = scl_s[1] & scl_s[2] & ~sda_s[1] & sda_s[2];
   assign sp_cond = scl_s[1] & scl_s[2] & sda_s[1] & ~sda_s[2];
   // live input values, inverted where the polarity bit is set
   assign live[0] = pin_s2[WIDTH-1:0] ^ pol_q[0];
   assign live[1] = pin_s2[2*WIDTH-1:WIDTH] ^ pol_q[1];
   // byte loaded into the shifter at the start of each read byte
   always_comb begin
      ld_byte = rd_mux(ptr, in_q[0], in_q[1]);
   end

   // bus state machine, pointer, shifter
   always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         state <= IOX_IDLE;
         sh <= 8'h00;
         bitn <= 4'h0;
         ack_slot <= 1'b0;
         ptr <= `IOX_PTR_RST;
         link.sda_d_oe <= 1'b0;
      end else if (sp_cond) begin
         state <= IOX_IDLE;
         link.sda_d_oe <= 1'b0;
      end else if (st_cond) begin
         state <= IOX_ADDR; // pointer untouched
         bitn <= 4'h0;
         ack_slot <= 1'b0;
         link.sda_d_oe <= 1'b0;
      end else if (scl_r && !ack_slot && state != IOX_IDLE && state != IOX_RDAT) begin
         sh <= {sh[6:0], sda_s[1]};
         bitn <= bitn + 4'h1;
      end else if (scl_r && ack_slot && state == IOX_RACK) begin
         ptr <= {ptr[2:1], ~ptr[0]};
         if (sda_s[1]) begin
            state <= IOX_IDLE;
         end else begin
            state <= IOX_RDAT;
         end
      end else if (scl_f) begin
         case (state)
            IOX_ADDR, IOX_CMD, IOX_WDAT: begin
               if (ack_slot) begin
                  ack_slot <= 1'b0;
                  bitn <= 4'h0;
                  link.sda_d_oe <= 1'b0;
                  if (state == IOX_RDAT) begin
                     link.sda_d_oe <= 1'b0;
                  end
               end else if (bitn == 4'd8) begin
                  ack_slot <= 1'b1;
                  if (state == IOX_ADDR) begin
                     if (sh[7:1] == `IOX_DEV_ADDR) begin
                        link.sda_d_oe <= 1'b1;
                        state <= sh[0] ? IOX_RDAT : IOX_CMD;
                     end else begin
                        state <= IOX_IDLE;
                        ack_slot <= 1'b0;
                     end
                  end else if (state == IOX_CMD) begin
                     ptr <= sh[2:0];
                     link.sda_d_oe <= 1'b1;
                     state <= IOX_WDAT;
                  end else begin
                     ptr <= {ptr[2:1], ~ptr[0]};
                     link.sda_d_oe <= 1'b1;
                  end
               end
               if (ack_slot && state == IOX_ADDR) begin
                  state <= IOX_IDLE;
               end
            end
            IOX_RDAT: begin
               // first falling edge after address ack loads the byte
               if (ack_slot || bitn == 4'h0) begin
                  ack_slot <= 1'b0;
                  sh <= ld_byte;
                  link.sda_d_oe <= ~ld_byte[7];
                  bitn <= 4'h1;
               end else if (bitn == 4'd8) begin
                  link.sda_d_oe <= 1'b0;
                  ack_slot <= 1'b1;
                  state <= IOX_RACK;
               end else begin
                  link.sda_d_oe <= ~sh[7-bitn[2:0]];
                  bitn <= bitn + 4'h1;
               end
            end
            IOX_RACK: link.sda_d_oe <= 1'b0;
            default: link.sda_d_oe <= 1'b0;
         endcase
      end
   end

   // write data into the pointed register
   always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         out_q <= '{default: `IOX_OUT_RST};
         pol_q <= '{default: `IOX_POL_RST};
         cfg_q <= '{default: `IOX_CFG_RST};
      end else if (scl_f && state == IOX_WDAT && !ack_slot && bitn == 4'd8) begin
         case (ptr[2:1])
            2'd1: out_q[ptr[0]] <= sh[WIDTH-1:0];
            2'd2: pol_q[ptr[0]] <= sh[WIDTH-1:0];
            2'd3: cfg_q[ptr[0]] <= sh[WIDTH-1:0];
            default: ;
         endcase
      end
   end

   // input capture at acknowledge rising edge; interrupt reference
   always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         in_q <= '{default: '0};
         int_ref <= '{default: '0};
      end else begin
         // ack of a read address or a read byte: source of the next byte
         if (scl_r && ack_slot && (state == IOX_RDAT || state == IOX_RACK)) begin
            in_q[0] <= live[0];
            in_q[1] <= live[1];
         end
         if (scl_r && state == IOX_RACK && ptr[2:1] == 2'd0) begin
            int_ref[ptr[0]] <= live[ptr[0]];
         end
      end
   end

   // interrupt on inputs differing from last read value
   always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         int_b_out <= 1'b1;
      end else begin
         int_b_out <= ~|(((live[0] ^ int_ref[0]) & cfg_q[0]) |
            ((live[1] ^ int_ref[1]) & cfg_q[1]));
      end
   end

   // port pad drive from output and configuration
   assign port_drive_out = {out_q[1], out_q[0]};
   assign port_oe_out = ~{cfg_q[1], cfg_q[0]};
endmodule : iox_device
`default_nettype wire

// file: rtl/iox_consts.svh
// iox_consts.svh: shared constants of the expander link, device and master ends
// assumes inclusion by bare name from rtl/ files
`ifndef IOX_CONSTS_SVH
`define IOX_CONSTS_SVH
`define IOX_REG_IN0 3'h0
`define IOX_REG_IN1 3'h1
`define IOX_REG_OUT0 3'h2
`define IOX_REG_POL0 3'h4
`define IOX_REG_CFG0 3'h6
`define IOX_OUT_RST 8'hFF
`define IOX_POL_RST 8'h00
`define IOX_CFG_RST 8'hFF
`define IOX_PTR_RST 3'h0
`define IOX_DEV_ADDR 7'h74
`define IOX_SYS_NS 100
`define IOX_SCL_HALF_NS 400
`define IOX_SCL_HALF_CYC ((`IOX_SCL_HALF_NS + `IOX_SYS_NS - 1) / `IOX_SYS_NS)
`endif

// file: rtl/iox_pkg.sv
// iox_pkg.sv: types shared by both ends of the expander link
// assumes nothing beyond a SystemVerilog compiler
package iox_pkg;
   typedef enum logic [1:0] {IOX_OP_READ_PTR, IOX_OP_READ_CUR} iox_op_t;
endpackage : iox_pkg

// file: rtl/iox_link_if.sv
// iox_link_if.sv: open-drain two-wire link between master and expander
// assumes wire levels are resolved here from the enables, not by the bench
`timescale 1ns/1ps
`default_nettype none
interface iox_link_if;
   logic scl_m_oe;
   logic sda_m_oe;
   logic sda_d_oe;
   logic scl;
   logic sda;
   // wired-and of the open-drain drivers
   assign scl = ~scl_m_oe;
   assign sda = ~(sda_m_oe | sda_d_oe);
   modport master (output scl_m_oe, output sda_m_oe, input scl, input sda);
   modport device (output sda_d_oe, input scl, input sda);
endinterface : iox_link_if
`default_nettype wire

// file: rtl/iox_master.sv
// iox_master.sv: bus master reading the expander register pairs
// assumes link wires resolved in the interface; sda sampled by two flops
`timescale 1ns/1ps
`default_nettype none
`include "iox_consts.svh"
module iox_master (
   input wire logic sys_clk_in,
   input wire logic rst_b_in,
   iox_link_if.master link,
   input wire logic req_in,
   input wire iox_pkg::iox_op_t op_in,
   input wire logic [2:0] cmd_in,
   input wire logic [7:0] count_in,
   output logic busy_out,
   output logic data_valid_out,
   output logic [7:0] data_out,
   output logic ack_err_out
);
   import iox_pkg::*;
   typedef enum logic [2:0] {IOXM_IDLE, IOXM_START, IOXM_BYTE, IOXM_ACK,
      IOXM_STOP} iox_m_state_t;
   iox_m_state_t state;
   logic [7:0] half_cnt;
   logic phase;
   logic [3:0] bitn;
   logic [7:0] tx;
   logic [7:0] rx;
   logic [1:0] stage;
   logic [7:0] left;
   logic [2:0] cmd;
   logic [1:0] sda_s;
   logic tick;

   assign tick = (half_cnt == 8'(`IOX_SCL_HALF_CYC - 1));
   assign busy_out = (state != IOXM_IDLE);

   // half-period timer of the generated clock
   always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         half_cnt <= 8'h00;
         sda_s <= 2'b11;
      end else begin
         half_cnt <= (tick || state == IOXM_IDLE) ? 8'h00 : half_cnt + 8'h01;
         sda_s <= {sda_s[0], link.sda};
      end
   end

   // transaction sequencer: stage 0 write addr, 1 cmd, 2 read addr, 3 data
   always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         state <= IOXM_IDLE;
         phase <= 1'b0;
         bitn <= 4'h0;
         tx <= 8'h00;
         rx <= 8'h00;
         stage <= 2'd0;
         left <= 8'h00;
         cmd <= 3'h0;
         link.scl_m_oe <= 1'b0;
         link.sda_m_oe <= 1'b0;
         data_valid_out <= 1'b0;
         data_out <= 8'h00;
         ack_err_out <= 1'b0;
      end else begin
         data_valid_out <= 1'b0;
         case (state)
            IOXM_IDLE: begin
               if (req_in) begin
                  left <= (count_in == 8'h00) ? 8'h01 : count_in;
                  cmd <= cmd_in;
                  ack_err_out <= 1'b0;
                  // skip the command when reading the current pointer
                  stage <= (op_in == IOX_OP_READ_CUR) ? 2'd2 : 2'd0;
                  tx <= (op_in == IOX_OP_READ_CUR) ? {`IOX_DEV_ADDR, 1'b1}
                     : {`IOX_DEV_ADDR, 1'b0};
                  phase <= 1'b0;
                  state <= IOXM_START;
               end
            end
            IOXM_START: if (tick) begin
               // release both, then pull sda while scl high
               phase <= ~phase;
               if (!phase) begin
                  link.sda_m_oe <= 1'b0;
                  link.scl_m_oe <= 1'b0;
               end else begin
                  link.sda_m_oe <= 1'b1;
                  state <= IOXM_BYTE;
                  bitn <= 4'h0;
                  phase <= 1'b0;
               end
            end
            // fall tick: sample the bit that just ended, pull scl, set sda;
            // sampling after a full high half gives the slave time to answer
            IOXM_BYTE: if (tick) begin
               phase <= ~phase;
               if (!phase) begin
                  link.scl_m_oe <= 1'b1;
                  if (bitn != 4'h0) begin
                     rx <= {rx[6:0], sda_s[1]};
                  end
                  if (bitn == 4'd8) begin
                     // nack the final byte, ack the rest
                     link.sda_m_oe <= (stage == 2'd3) ? (left != 8'h01) : 1'b0;
                     state <= IOXM_ACK;
                  end else begin
                     link.sda_m_oe <= (stage == 2'd3) ? 1'b0 : ~tx[7];
                     tx <= {tx[6:0], 1'b0};
                  end
               end else begin
                  link.scl_m_oe <= 1'b0;
                  bitn <= bitn + 4'h1;
               end
            end
            // rise tick releases scl; fall tick reads the ack and moves on
            IOXM_ACK: if (tick) begin
               phase <= ~phase;
               if (!phase) begin
                  link.scl_m_oe <= 1'b1;
                  link.sda_m_oe <= 1'b0;
                  bitn <= 4'h0;
                  if (stage == 2'd3) begin
                     data_out <= rx;
                     data_valid_out <= 1'b1;
                     left <= left - 8'h01;
                     if (left == 8'h01) begin
                        link.sda_m_oe <= 1'b1; // sda low ahead of the stop
                        state <= IOXM_STOP;
                        phase <= 1'b0;
                     end else begin
                        state <= IOXM_BYTE;
                     end
                  end else if (sda_s[1]) begin
                     ack_err_out <= 1'b1;
                     link.sda_m_oe <= 1'b1;
                     state <= IOXM_STOP;
                     phase <= 1'b0;
                  end else if (stage == 2'd0) begin
                     stage <= 2'd1;
                     link.sda_m_oe <= 1'b1; // command bit 7 is always zero
                     tx <= {4'h0, cmd, 1'b0};
                     state <= IOXM_BYTE;
                  end else if (stage == 2'd1) begin
                     stage <= 2'd2;
                     tx <= {`IOX_DEV_ADDR, 1'b1};
                     state <= IOXM_START;
                     phase <= 1'b0;
                  end else begin
                     stage <= 2'd3;
                     state <= IOXM_BYTE;
                  end
               end else begin
                  link.scl_m_oe <= 1'b0;
               end
            end
            // scl rises with sda held low, then sda rises: a stop
            IOXM_STOP: if (tick) begin
               phase <= ~phase;
               if (!phase) begin
                  link.scl_m_oe <= 1'b0;
               end else begin
                  link.sda_m_oe <= 1'b0;
                  state <= IOXM_IDLE;
               end
            end
            default: state <= IOXM_IDLE;
         endcase
      end
   end
endmodule : iox_master
`default_nettype wire

// file: sim/iox_assertions.sv
// iox_assertions.sv: wire-level checks on the link between master and expander
// assumes resolved wires and enables of one iox_link_if, one clock domain
`timescale 1ns/1ps
`default_nettype none
module iox_assertions (
   input wire logic sys_clk_in,
   input wire logic rst_b_in,
   input wire logic scl_m_oe,
   input wire logic sda_m_oe,
   input wire logic sda_d_oe,
   input wire logic scl,
   input wire logic sda
);
   logic scl_q;
   logic sda_q;
   logic in_frame;
   logic [7:0] drive_cnt;
   logic start_c;
   logic stop_c;
   default clocking cb @(posedge sys_clk_in);
   endclocking
   default disable iff (!rst_b_in);
   // start and stop are sda edges while scl stays high
   assign start_c = scl_q & scl & sda_q & ~sda;
   assign stop_c = scl_q & scl & ~sda_q & sda;
   // previous wire levels
   always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
      end else begin
         scl_q <= scl;
         sda_q <= sda;
      end
   end
   // frame tracker between start and stop
   always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         in_frame <= 1'b0;
      end else if (start_c) begin
         in_frame <= 1'b1;
      end else if (stop_c) begin
         in_frame <= 1'b0;
      end
   end
   // length of one unbroken device pull
   always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         drive_cnt <= 8'h00;
      end else if (!sda_d_oe) begin
         drive_cnt <= 8'h00;
      end else if (drive_cnt != 8'hff) begin
         drive_cnt <= drive_cnt + 8'h01;
      end
   end
   chk_reset_idle: assert property ($rose(rst_b_in) |-> !sda_d_oe && !scl_m_oe && !sda_m_oe)
      else $error("link driven right after reset");
   chk_hold_high: assert property (scl && $past(scl) |-> $stable(sda_d_oe))
      else $error("device sda changed while scl high");
   chk_change_low: assert property ($changed(sda_d_oe) |-> !scl)
      else $error("device sda changed outside scl low");
   chk_start_quiet: assert property (start_c |-> !sda_d_oe [*8])
      else $error("device drives sda at start");
   chk_stop_release: assert property (stop_c |-> !sda_d_oe [*8])
      else $error("device drives sda at stop");
   chk_drive_in_frame: assert property (sda_d_oe |-> in_frame)
      else $error("device drives sda outside a frame");
   chk_drive_bounded: assert property (sda_d_oe |-> drive_cnt < 8'd80)
      else $error("device holds sda past one bit and byte");
   chk_scl_low_min: assert property ($fell(scl) |-> !scl [*4])
      else $error("scl low phase too short");
   chk_scl_high_min: assert property ($rose(scl) |-> scl [*4])
      else $error("scl high phase too short");
   // main scenarios reached
   cov_restart: cover property (start_c && in_frame);
   cov_stop: cover property (stop_c);
   cov_dev_drive: cover property ($rose(sda_d_oe));
   cov_long_drive: cover property (drive_cnt > 8'd60);
endmodule : iox_assertions
`default_nettype wire

// file: sim/test_io_expander_i2c_read_path.sv
// test_io_expander_i2c_read_path.sv: master and expander joined on one link
// assumes 10 MHz clock; pins from the bench, other registers at reset values
`timescale 1ns/1ps
`default_nettype none
module test_io_expander_i2c_read_path;
   import iox_pkg::*;
   logic sys_clk_in;
   logic rst_b_in;
   logic [15:0] port_pins_in;
   logic [15:0] port_drive_out;
   logic [15:0] port_oe_out;
   logic int_b_out;
   logic req_in;
   iox_op_t op_in;
   logic [2:0] cmd_in;
   logic [7:0] count_in;
   logic busy_out;
   logic data_valid_out;
   logic [7:0] data_out;
   logic ack_err_out;
   logic [2:0] ptr;
   int failures = 0;
   int cmp_count = 0;
   iox_link_if link_if();
   iox_device iox_device_inst (.sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in), .link(link_if),
      .port_pins_in(port_pins_in), .port_drive_out(port_drive_out),
      .port_oe_out(port_oe_out), .int_b_out(int_b_out));
   iox_master iox_master_inst (.sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in), .link(link_if),
      .req_in(req_in), .op_in(op_in), .cmd_in(cmd_in), .count_in(count_in),
      .busy_out(busy_out), .data_valid_out(data_valid_out), .data_out(data_out),
      .ack_err_out(ack_err_out));
   iox_assertions iox_assertions_inst (.sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in),
      .scl_m_oe(link_if.scl_m_oe), .sda_m_oe(link_if.sda_m_oe), .sda_d_oe(link_if.sda_d_oe),
      .scl(link_if.scl), .sda(link_if.sda));
   // compare helpers
   task automatic cmp_val(input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp) begin
         failures++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : cmp_val
   task automatic cmp_bit(input logic got, input logic exp);
      cmp_count++;
      if (got !== exp) begin
         failures++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : cmp_bit
   // expected register contents: inputs pass through, others at reset value
   function automatic logic [7:0] exp_reg(input logic [2:0] r, input logic [15:0] pins);
      case (r)
         3'h0: exp_reg = pins[7:0];
         3'h1: exp_reg = pins[15:8];
         3'h4, 3'h5: exp_reg = 8'h00;
         default: exp_reg = 8'hff;
      endcase
   endfunction : exp_reg
   task automatic close_out();
      $display("comparisons %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : close_out
   // one request pulse, pins set with it
   task automatic go(input iox_op_t op, input logic [2:0] cmd, input logic [7:0] cnt,
         input logic [15:0] pins);
      @(negedge sys_clk_in);
      port_pins_in = pins;
      op_in = op;
      cmd_in = cmd;
      count_in = cnt;
      req_in = 1'b1;
      @(negedge sys_clk_in);
      req_in = 1'b0;
   endtask : go
   // full transfer, each byte checked against the pointer model
   task automatic run(input iox_op_t op, input logic [2:0] cmd, input logic [7:0] cnt,
         input logic [15:0] pins);
      logic [15:0] got;
      int guard;
      got = 16'h0000;
      guard = 0;
      go(op, cmd, cnt, pins);
      if (op == IOX_OP_READ_PTR) begin
         ptr = cmd;
      end
      while (busy_out !== 1'b0 && guard < 4000) begin
         if (data_valid_out === 1'b1) begin
            cmp_val({8'h00, data_out}, {8'h00, exp_reg(ptr, pins)});
            ptr[0] = ~ptr[0];
            got++;
         end
         guard++;
         @(negedge sys_clk_in);
      end
      cmp_bit(busy_out, 1'b0);
      cmp_val(got, {8'h00, (cnt == 8'h00) ? 8'h01 : cnt});
      cmp_bit(ack_err_out, 1'b0);
   endtask : run
   initial begin
      sys_clk_in = 1'b0;
      forever #50 sys_clk_in = ~sys_clk_in;
   end
   // hang guard, well past the expected run length
   initial begin
      #(60_000 * 100);
      failures++;
      close_out();
   end
   initial begin
      logic [15:0] p;
      rst_b_in = 1'b0;
      req_in = 1'b0;
      op_in = IOX_OP_READ_CUR;
      cmd_in = 3'h0;
      count_in = 8'h00;
      port_pins_in = 16'h0000;
      ptr = 3'h0;
      p = 16'($urandom(75061));
      repeat (12) @(negedge sys_clk_in);
      cmp_bit(int_b_out, 1'b1);
      cmp_val(port_oe_out, 16'h0000);
      cmp_val(port_drive_out, 16'hffff);
      rst_b_in = 1'b1;
      run(IOX_OP_READ_CUR, 3'h0, 8'h01, 16'($urandom));
      for (int c = 0; c < 8; c++) begin
         run(IOX_OP_READ_PTR, 3'(c), 8'(c % 3 + 1), 16'($urandom));
         run(IOX_OP_READ_CUR, 3'h0, 8'h01, 16'($urandom));
      end
      run(IOX_OP_READ_PTR, 3'h1, 8'h09, 16'($urandom));
      run(IOX_OP_READ_PTR, 3'h3, 8'h00, 16'($urandom));
      // interrupt raised by a pin change and cleared by the read
      p = 16'($urandom);
      run(IOX_OP_READ_PTR, 3'h0, 8'h02, p);
      repeat (10) @(negedge sys_clk_in);
      cmp_bit(int_b_out, 1'b1);
      port_pins_in = p ^ 16'h0008;
      repeat (10) @(negedge sys_clk_in);
      cmp_bit(int_b_out, 1'b0);
      run(IOX_OP_READ_PTR, 3'h0, 8'h01, p ^ 16'h0008);
      cmp_bit(int_b_out, 1'b1);
      for (int i = 0; i < 12; i++) begin
         run($urandom_range(1, 0) ? IOX_OP_READ_PTR : IOX_OP_READ_CUR, 3'($urandom),
            8'($urandom_range(6, 1)), 16'($urandom));
      end
      // reset in mid-transfer, then read without command
      go(IOX_OP_READ_PTR, 3'h5, 8'h04, 16'($urandom));
      repeat (150) @(negedge sys_clk_in);
      rst_b_in = 1'b0;
      repeat (2) @(negedge sys_clk_in);
      cmp_bit(busy_out, 1'b0);
      cmp_bit(int_b_out, 1'b1);
      rst_b_in = 1'b1;
      ptr = 3'h0;
      run(IOX_OP_READ_CUR, 3'h0, 8'h02, 16'($urandom));
      close_out();
   end
endmodule : test_io_expander_i2c_read_path
`default_nettype wire
